// [hw/i2c_target.sv]
// I2C target port with paged 16-bit register addressing
`timescale 1ns/1ps
module i2c_target
    import i2c_target_pkg::*;
#(
    parameter int STORE_ADDR_WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address configuration
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    input wire logic addr_bit_two_gpio,
    input wire logic addr_bit_two_gpio_default,
    input wire logic addr_load_valid,
    input wire logic [6:0] addr_load_value,
    input wire logic two_byte_offset_mode,
    // Register access toward the device
    output reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Status
    output logic [31:0] page_select,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK,
        ST_READ, ST_READ_ACK
    } state_t;

    // ------------------------------------------------------------
    // Pin sampling and bus conditions
    // ------------------------------------------------------------
    // Two stage history; at 20 MHz a 1 MHz bit gives twenty samples
    logic [1:0] scl_h_r;
    logic [1:0] sda_h_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_h_r <= 2'b11;
            sda_h_r <= 2'b11;
        end else begin
            scl_h_r <= {scl_h_r[0], scl_in};
            sda_h_r <= {sda_h_r[0], sda_in};
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_h_r == 2'b01;
    assign scl_fall = scl_h_r == 2'b10;
    assign start_c = scl_h_r[1] && scl_h_r[0] && sda_h_r == 2'b10;
    assign stop_c = scl_h_r[1] && scl_h_r[0] && sda_h_r == 2'b01;

    // ------------------------------------------------------------
    // Bus address resolution
    // ------------------------------------------------------------
    logic [6:0] base_addr_r;
    logic rst_seen_r;
    // Load value or GPIO bit two is caught after reset release, never in reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            base_addr_r <= PRIMARY_ADDR_DEFAULT;
            rst_seen_r <= 1'b0;
        end else if (!rst_seen_r) begin
            rst_seen_r <= 1'b1;
            if (addr_load_valid) begin
                base_addr_r <= addr_load_value;
            end else if (addr_bit_two_gpio_default) begin
                base_addr_r[2] <= addr_bit_two_gpio;
            end
        end
    end
    logic [6:0] primary_addr;
    // Straps assumed static, so sampled directly
    assign primary_addr = {base_addr_r[6:2], addr_strap_high,
                           addr_strap_low};

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic rw_r, sec_r, nack_r;
    logic [1:0] offs_cnt_r;
    logic [15:0] ptr_r;
    logic [2:0] page_cnt_r;
    logic in_page_r;
    logic [7:0] tx_r;

    logic addr_hit;
    assign addr_hit = shift_r[7:1] == primary_addr ||
                      shift_r[7:1] == SECONDARY_ADDR;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'd0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            sec_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (start_c) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'd0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
        end else if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'd1;
            unique case (state_r)
                ST_ADDR, ST_WRITE: begin
                    shift_r <= {shift_r[6:0], sda_h_r[1]};
                end
                ST_READ_ACK: begin
                    nack_r <= sda_h_r[1];
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_r)
                ST_ADDR: begin
                    if (bit_cnt_r == 4'd8) begin
                        if (addr_hit) begin
                            state_r <= ST_ADDR_ACK;
                            rw_r <= shift_r[0];
                            sec_r <= shift_r[7:1] == SECONDARY_ADDR;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WRITE_ACK: begin
                    state_r <= rw_r ? ST_READ : ST_WRITE;
                    bit_cnt_r <= 4'd0;
                end
                ST_WRITE: begin
                    if (bit_cnt_r == 4'd8) begin
                        state_r <= ST_WRITE_ACK;
                    end
                end
                ST_READ: begin
                    if (bit_cnt_r == 4'd8) begin
                        state_r <= ST_READ_ACK;
                    end
                end
                ST_READ_ACK: begin
                    state_r <= nack_r ? ST_IDLE : ST_READ;
                    bit_cnt_r <= 4'd0;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Offset capture, pointer and page register
    // ------------------------------------------------------------
    logic wbyte_end;
    assign wbyte_end = scl_fall && state_r == ST_WRITE &&
                       bit_cnt_r == 4'd8;
    logic rbyte_end;
    assign rbyte_end = scl_fall && state_r == ST_READ &&
                       bit_cnt_r == 4'd8;
    logic offs_need;
    assign offs_need = offs_cnt_r < (two_byte_offset_mode ? 2'd2 : 2'd1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            offs_cnt_r <= 2'd0;
            ptr_r <= 16'h0000;
            page_select <= PAGE_SELECT_RESET;
            page_cnt_r <= 3'd0;
            in_page_r <= 1'b0;
        end else if (start_c) begin
            offs_cnt_r <= 2'd0;
        end else if (wbyte_end && offs_need) begin
            offs_cnt_r <= offs_cnt_r + 2'd1;
            if (two_byte_offset_mode) begin
                ptr_r <= {ptr_r[7:0], shift_r};
                in_page_r <= {ptr_r[7:0], shift_r} ==
                             PAGE_SELECT_OFFSET;
            end else begin
                ptr_r <= {page_select[15:8], shift_r};
                in_page_r <= shift_r ==
                             PAGE_SELECT_SHORT_OFFSET;
            end
            page_cnt_r <= 3'd0;
        end else if (wbyte_end || rbyte_end) begin
            if (wbyte_end && in_page_r && page_cnt_r < 3'd4) begin
                // Page bytes go in low byte first
                page_select[page_cnt_r[1:0]*8 +: 8] <= shift_r;
                page_cnt_r <= page_cnt_r + 3'd1;
            end
            if (two_byte_offset_mode) begin
                ptr_r <= ptr_r + 16'd1;
            end else begin
                // Page wraps rather than crossing; controller avoids it
                ptr_r[7:0] <= ptr_r[7:0] + 8'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register requests and read path
    // ------------------------------------------------------------
    logic [7:0] store_rdata;
    logic [7:0] page_byte;
    assign page_byte = page_select[ptr_r[1:0]*8 +: 8];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_req <= '0;
        end else begin
            reg_req.we <= wbyte_end && !offs_need && !in_page_r &&
                          ptr_r[USER_SPACE_BIT] | sec_r;
            reg_req.re <= (scl_fall && state_r == ST_ADDR_ACK && rw_r) ||
                          (scl_fall && state_r == ST_READ_ACK && !nack_r);
            reg_req.addr <= ptr_r;
            reg_req.wdata <= shift_r;
            reg_req.secondary <= sec_r;
        end
    end

    // Page register reads back from its own storage; lower half reads 0 on the primary address
    logic [7:0] rd_byte;
    assign rd_byte = in_page_r ? page_byte : sec_r ? store_rdata :
                     ptr_r[USER_SPACE_BIT] ? reg_rdata : 8'h00;
    // Reserved registers behind the secondary address are kept locally
    reg_store #(.ADDR_WIDTH(STORE_ADDR_WIDTH)) reserved_store (
        .clk(clk), .we(wbyte_end && !offs_need && !in_page_r && sec_r),
        .addr(ptr_r[STORE_ADDR_WIDTH-1:0]), .wdata(shift_r),
        .rdata(store_rdata)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_r <= 8'h00;
        end else if (scl_fall && state_r == ST_READ && bit_cnt_r < 4'd8) begin
            tx_r <= {tx_r[6:0], 1'b0};
        end else if (scl_fall && (state_r == ST_ADDR_ACK ||
                                  state_r == ST_READ_ACK)) begin
            tx_r <= rd_byte;
        end
    end

    // ------------------------------------------------------------
    // SDA drive: open drain, low only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe <= 1'b0;
        end else if (scl_fall || start_c || stop_c) begin
            sda_oe <= 1'b0;
            if (scl_fall && !start_c && !stop_c) begin
                if (state_r == ST_ADDR && bit_cnt_r == 4'd8) begin
                    sda_oe <= addr_hit;
                end else if (state_r == ST_WRITE && bit_cnt_r == 4'd8) begin
                    sda_oe <= 1'b1;
                end else if ((state_r == ST_ADDR_ACK && rw_r) ||
                             (state_r == ST_READ && bit_cnt_r < 4'd8) ||
                             (state_r == ST_READ_ACK && !nack_r)) begin
                    sda_oe <= (state_r == ST_READ) ? !tx_r[6] : !rd_byte[7];
                end
            end
        end
    end
    assign sda_out = 1'b0;
    assign busy = state_r != ST_IDLE;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    foreign_no_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'd8 && !addr_hit &&
         !start_c && !stop_c) |=> !sda_oe && state_r == ST_IDLE)
        else $error("foreign address acknowledged");
    own_addr_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'd8 && addr_hit &&
         !start_c && !stop_c) |=> sda_oe && state_r == ST_ADDR_ACK)
        else $error("own address not acknowledged");
    ptr_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rbyte_end && !start_c && !stop_c) |=>
        ptr_r[7:0] == $past(ptr_r[7:0]) + 8'd1)
        else $error("pointer did not advance");
    one_byte_page_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wbyte_end && !start_c && !stop_c && !two_byte_offset_mode &&
         offs_cnt_r == 2'd0 && !rw_r) |=>
        ptr_r == {page_select[15:8], $past(shift_r)})
        else $error("paged address wrong");
    page_window_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wbyte_end && !start_c && !stop_c && !two_byte_offset_mode &&
         offs_need && !rw_r && shift_r == 8'hfc) |=> in_page_r)
        else $error("page register not selected");
    lower_half_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_req.we |-> reg_req.addr[USER_SPACE_BIT] || reg_req.secondary)
        else $error("write into lower half");
    default_addr_a: assert property (@(posedge clk)
        $rose(reset_n) |-> base_addr_r == PRIMARY_ADDR_DEFAULT)
        else $error("primary address default wrong");
    strap_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        (scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'd8 && !start_c &&
         !stop_c && shift_r[7:1] == {base_addr_r[6:2], addr_strap_high,
         addr_strap_low}) |=> sda_oe)
        else $error("strap bits not applied");
    cv_write_c: cover property (@(posedge clk) disable iff (!reset_n)
        reg_req.we);
    cv_read_c: cover property (@(posedge clk) disable iff (!reset_n)
        reg_req.re);
    cv_page_c: cover property (@(posedge clk) disable iff (!reset_n)
        wbyte_end && in_page_r);
endmodule : i2c_target

// [hw/i2c_target_pkg.sv]
// Package: constants and types for the paged I2C register target
package i2c_target_pkg;
    localparam logic [6:0] SECONDARY_ADDR = 7'h09;
    localparam logic [6:0] PRIMARY_ADDR_DEFAULT = 7'h58;
    localparam logic [15:0] PAGE_SELECT_OFFSET = 16'hfffc;
    localparam logic [7:0] PAGE_SELECT_SHORT_OFFSET = 8'hfc;
    localparam logic [31:0] PAGE_SELECT_RESET = 32'h0000_0000;
    localparam int REG_ADDR_WIDTH = 16;
    localparam int USER_SPACE_BIT = 15;
    localparam int CLK_HZ = 20_000_000;
    localparam int GLITCH_FILTER_CYCLES = 2;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic secondary;
    } reg_req_t;
endpackage : i2c_target_pkg

// [hw/reg_store.sv]
// Small register memory with registered read data
`timescale 1ns/1ps
module reg_store
    import i2c_target_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic we,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_r [0:(1<<ADDR_WIDTH)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[addr] <= wdata;
        end
        rdata <= mem_r[addr];
    end
endmodule : reg_store

// [testbench/i2c_ctl_model.sv]
// Behavioural I2C bus controller that drives the target's pins
`timescale 1ns/1ps
module i2c_ctl_model #(
    parameter int HALF = 10
) (
    // Clock
    input wire logic clk,
    // Bus pins, open drain: a high drive pulls the line low
    output logic scl_low,
    output logic sda_low,
    input wire logic sda_line
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    // Also serves as repeated start, SCL low on entry
    task automatic start();
        sda_low <= 1'b0;
        tick(HALF);
        scl_low <= 1'b0;
        tick(HALF);
        sda_low <= 1'b1;
        tick(HALF);
        scl_low <= 1'b1;
        tick(HALF);
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        tick(HALF);
        scl_low <= 1'b0;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask : stop

    // SDA moves one cycle after SCL falls so no false start is seen
    task automatic put_bit(input logic b);
        sda_low <= !b;
        tick(HALF);
        scl_low <= 1'b0;
        tick(HALF);
        scl_low <= 1'b1;
        tick(1);
    endtask : put_bit

    task automatic get_bit(output logic b);
        sda_low <= 1'b0;
        tick(HALF);
        scl_low <= 1'b0;
        tick(HALF / 2);
        b = sda_line;
        tick(HALF - HALF / 2);
        scl_low <= 1'b1;
        tick(1);
    endtask : get_bit

    // ----------------------------------------------------------------
    // Bytes
    // ----------------------------------------------------------------
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = !b;
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask : rd_byte
endmodule : i2c_ctl_model

// [testbench/i2c_target_tb.sv]
// Self-checking bench for the paged I2C register target
`timescale 1ns/1ps
module i2c_target_tb;
    import i2c_target_pkg::*;
    logic clk;
    logic reset_n;
    logic scl_low;
    logic sda_low;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic two_byte_offset_mode;
    logic gpio_level;
    logic gpio_default_en;
    logic load_valid;
    logic [6:0] load_value;
    int re_count = 0;
    logic busy;
    logic [7:0] reg_rdata;
    logic [31:0] page_select;
    reg_req_t reg_req;
    reg_req_t wr_log [$];
    int errors;
    int num_checks;

    // Pull-up on SDA: low when either party pulls
    assign sda_line = !(sda_low || (sda_oe && !sda_out));
    // Register image holds a pattern of the low address byte
    assign reg_rdata = reg_req.addr[7:0] ^ 8'h5a;

    always @(posedge clk) begin
        if (reg_req.we === 1'b1) begin
            wr_log.push_back(reg_req);
        end
        if (reg_req.re === 1'b1) begin
            re_count++;
        end
    end

    i2c_target DUT (
        .clk(clk), .reset_n(reset_n), .scl_in(!scl_low),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_low(1'b1), .addr_strap_high(1'b1),
        .addr_bit_two_gpio(gpio_level),
        .addr_bit_two_gpio_default(gpio_default_en),
        .addr_load_valid(load_valid), .addr_load_value(load_value),
        .two_byte_offset_mode(two_byte_offset_mode),
        .reg_req(reg_req), .reg_rdata(reg_rdata),
        .page_select(page_select), .busy(busy)
    );

    // 10 cycles a half bit gives 1 MHz SCL
    i2c_ctl_model #(.HALF(10)) ctl (
        .clk(clk), .scl_low(scl_low), .sda_low(sda_low),
        .sda_line(sda_line)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask : chk

    task automatic results();
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic send(input logic [6:0] dev, input logic [7:0] q [$],
                        input logic ack_exp, input logic do_stop);
        logic ack;
        ctl.start();
        ctl.wr_byte({dev, 1'b0}, ack);
        chk("address ack", 32'(ack_exp), 32'(ack));
        if (ack_exp === 1'b0) begin
            chk("idle after refusal", 32'h0000_0000, 32'(busy));
        end
        if (ack === 1'b1) begin
            foreach (q[i]) begin
                ctl.wr_byte(q[i], ack);
                chk("data ack", 32'h0000_0001, 32'(ack));
            end
        end
        if (do_stop) begin
            ctl.stop();
        end
    endtask : send

    task automatic expect_wr(input logic [15:0] a, input logic [7:0] d);
        reg_req_t r;
        chk("write seen", 32'h0000_0001, 32'(wr_log.size() > 0));
        if (wr_log.size() > 0) begin
            r = wr_log.pop_front();
            chk("write addr", 32'(a), 32'(r.addr));
            chk("write data", 32'(d), 32'(r.wdata));
        end
    endtask : expect_wr

    // Offset write without stop, repeated start, then read
    task automatic read_back(input logic [6:0] dev, input logic [7:0] q [$],
                             input logic [7:0] e [$]);
        logic ack;
        logic [7:0] d;
        int n0;
        n0 = re_count;
        send(dev, q, 1'b1, 1'b0);
        ctl.start();
        ctl.wr_byte({dev, 1'b1}, ack);
        chk("read address ack", 32'h0000_0001, 32'(ack));
        foreach (e[i]) begin
            ctl.rd_byte(i == e.size() - 1, d);
            chk("read data", 32'(e[i]), 32'(d));
        end
        ctl.stop();
        chk("write count", 32'h0000_0000, 32'(wr_log.size()));
        chk("read strobes", 32'(e.size()), 32'(re_count - n0));
    endtask : read_back

    // Reset in mid-run with the given address sources applied
    task automatic reboot(input logic dflt, input logic gpio,
                          input logic ld, input logic [6:0] val);
        @(posedge clk);
        reset_n <= 1'b0;
        gpio_default_en <= dflt;
        gpio_level <= gpio;
        load_valid <= ld;
        load_value <= val;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("page reset", 32'h0000_0000, page_select);
    endtask : reboot

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_address();
        send(7'h58, {8'h10, 8'h33}, 1'b0, 1'b1);
        chk("write count", 32'h0000_0000, 32'(wr_log.size()));
        send(7'h09, {8'h10, 8'ha5}, 1'b1, 1'b1);
        chk("secondary", 32'h0000_0001, 32'(wr_log[0].secondary));
        expect_wr(16'h0010, 8'ha5);
        read_back(7'h09, {8'h10}, {8'ha5});
    endtask : t_address

    task automatic t_one_byte();
        send(7'h5b, {8'hfc, 8'h00, 8'hcb, 8'h10, 8'h20}, 1'b1, 1'b1);
        chk("page", 32'h2010_cb00, page_select);
        chk("write count", 32'h0000_0000, 32'(wr_log.size()));
        send(7'h5b, {8'he4, 8'h50, 8'h51}, 1'b1, 1'b1);
        expect_wr(16'hcbe4, 8'h50);
        expect_wr(16'hcbe5, 8'h51);
        read_back(7'h5b, {8'h24}, {8'h7e, 8'h7f});
    endtask : t_one_byte

    task automatic t_two_byte();
        @(posedge clk);
        two_byte_offset_mode <= 1'b1;
        @(posedge clk);
        send(7'h5b, {8'hff, 8'hfc, 8'h44, 8'h33, 8'h22, 8'h11},
             1'b1, 1'b1);
        chk("page", 32'h1122_3344, page_select);
        send(7'h5b, {8'hcb, 8'he4, 8'h50}, 1'b1, 1'b1);
        expect_wr(16'hcbe4, 8'h50);
        send(7'h5b, {8'h12, 8'h34, 8'h77}, 1'b1, 1'b1);
        chk("write count", 32'h0000_0000, 32'(wr_log.size()));
        read_back(7'h5b, {8'h00, 8'h10}, {8'h00});
        read_back(7'h5b, {8'hc0, 8'hff}, {8'ha5, 8'h5a});
    endtask : t_two_byte

    task automatic t_reset_cfg();
        reboot(1'b1, 1'b1, 1'b0, 7'h00);
        send(7'h5f, {8'h80}, 1'b1, 1'b1);
        send(7'h5b, {8'h80}, 1'b0, 1'b1);
        reboot(1'b1, 1'b1, 1'b1, 7'h20);
        send(7'h23, {8'h80}, 1'b1, 1'b1);
        send(7'h5f, {8'h80}, 1'b0, 1'b1);
        reboot(1'b0, 1'b0, 1'b0, 7'h00);
        send(7'h5b, {8'h80}, 1'b1, 1'b1);
        chk("write count", 32'h0000_0000, 32'(wr_log.size()));
    endtask : t_reset_cfg

    // ----------------------------------------------------------------
    // Clock, reset, sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        two_byte_offset_mode = 1'b0;
        gpio_level = 1'b0;
        gpio_default_en = 1'b0;
        load_valid = 1'b0;
        load_value = 7'h00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_address();
        t_one_byte();
        t_two_byte();
        t_reset_cfg();
        results();
    end
endmodule : i2c_target_tb
